//--- pkg/tfs_pkg.sv
// constants, register map and state encoding of the frame trigger sequencer
package tfs_pkg;

  // ==========================================================
  // clocks and timing
  localparam int PCLK_PERIOD_NS     = 5;
  localparam int CORE_PERIOD_NS     = 25;
  localparam int CORE_DIV           = CORE_PERIOD_NS / PCLK_PERIOD_NS;
  localparam int WAKE_MULT          = 64;
  localparam int WAKE_OFFSET        = 2;
  localparam int TRIG_MIN_NS        = 100;
  localparam int TRIG_MAX_NS        = 1000;
  localparam int RESET_MIN_NS       = 30000;
  localparam int TRIG_MIN_CYC       = (TRIG_MIN_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int TRIG_MAX_CYC       = TRIG_MAX_NS / PCLK_PERIOD_NS;
  localparam int RESET_MIN_CYC      = (RESET_MIN_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int SUBFRAME_CORE_CLKS = 10000;
  localparam int INTEG_CORE_CLKS    = 8192;
  localparam int SUBFRAME_CYC       = SUBFRAME_CORE_CLKS * CORE_DIV;
  localparam int INTEG_CYC          = INTEG_CORE_CLKS * CORE_DIV;
  localparam int LOW_CNT_W          = 13;
  localparam int WAKE_CNT_W         = 24;
  localparam int SUB_CNT_W          = 16;

  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MODE   = 8'h04;
  localparam logic [7:0] REG_WAKE   = 8'h08;
  localparam logic [7:0] REG_FRAME  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;

  localparam int CTRL_SOFT_BIT   = 0;
  localparam int MODE_SEL_LSB    = 0;
  localparam int MODE_FRAMES_LSB = 2;
  localparam int STATUS_FR_LSB   = 4;
  localparam int RESULT_PH_LSB   = 16;

  localparam logic [1:0]  MODE_CONT      = 2'h0;
  localparam logic [1:0]  MODE_SINGLE    = 2'h3;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic [5:0]  FRAMES_RESET   = 6'h01;
  localparam logic [13:0] WAKE_RESET     = 14'h00FA;
  localparam logic [11:0] NSUB_RESET     = 12'h000;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_WAKE  = 4'b0100,
    ST_FRAME = 4'b1000
  } tfs_seq_e;

endpackage

//--- hw/tfs_sequencer.sv
// frame trigger sequencer: wake delay, frame timing, pin and soft triggers, apb registers
`timescale 1ns/1ps
`default_nettype none

module tfs_sequencer #(
  parameter int RESET_CYC    = tfs_pkg::RESET_MIN_CYC,
  parameter int SUBFRAME_CYC = tfs_pkg::SUBFRAME_CYC,
  parameter int INTEG_CYC    = tfs_pkg::INTEG_CYC
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // combined reset/trigger pin
  input  wire logic        reset_trigger_pin_n,
  // depth engine results
  input  wire logic        depth_result_valid,
  input  wire logic [15:0] depth_amplitude,
  input  wire logic [15:0] depth_phase,
  // frame timing outputs
  output logic             frame_start_strobe,
  output logic             sensor_integrate,
  output logic             illum_enable,
  output logic             depth_compute,
  output logic             sample_ready,
  output logic             deep_sleep
);

  // ==========================================================
  // state
  typedef struct packed {
    tfs_pkg::tfs_seq_e                state;
    logic                             pin_meta;
    logic                             pin_sync;
    logic                             pin_prev;
    logic [tfs_pkg::LOW_CNT_W-1:0]    low_cnt;
    logic [tfs_pkg::WAKE_CNT_W-1:0]   wake_cnt;
    logic [tfs_pkg::SUB_CNT_W-1:0]    sub_cyc;
    logic [11:0]                      sub_idx;
    logic [6:0]                       frames_left;
    logic [6:0]                       frames_done;
    logic                             one_shot;
    logic                             soft_trig;
    logic [1:0]                       mode;
    logic [5:0]                       frames_cfg;
    logic [13:0]                      wake_cfg;
    logic [11:0]                      nsub_cfg;
    logic [15:0]                      amp;
    logic [15:0]                      phase;
    logic                             frame_start_strobe;
    logic                             sensor_integrate;
    logic                             illum_enable;
    logic                             depth_compute;
    logic                             sample_ready;
    logic                             deep_sleep;
    logic                             pready;
    logic                             pslverr;
    logic [31:0]                      prdata;
  } tfs_state_s;

  localparam tfs_state_s RESET_S = '{
    state: tfs_pkg::ST_IDLE, pin_meta: 1'b1, pin_sync: 1'b1, pin_prev: 1'b1,
    mode: tfs_pkg::MODE_RESET, frames_cfg: tfs_pkg::FRAMES_RESET,
    wake_cfg: tfs_pkg::WAKE_RESET, nsub_cfg: tfs_pkg::NSUB_RESET,
    default: '0
  };

  tfs_state_s s;
  tfs_state_s next_s;

  logic                            apb_acc;
  logic                            apb_wr;
  logic                            pin_trig;
  logic                            pin_reset;
  logic                            soft_go;
  logic                            trig_go;
  logic [6:0]                      frames_eff;
  logic [tfs_pkg::WAKE_CNT_W-1:0]  wake_total;
  logic [31:0]                     rdata;
  logic                            rd_err;

  // ==========================================================
  // combinational helpers
  always_comb begin
    apb_acc    = psel & penable;
    apb_wr     = apb_acc & s.pready & pwrite;
    // trigger window measured on the synchronised pin
    pin_trig   = s.pin_sync & ~s.pin_prev
               & (s.low_cnt > 13'(tfs_pkg::TRIG_MIN_CYC))
               & (s.low_cnt < 13'(tfs_pkg::TRIG_MAX_CYC));
    pin_reset  = ~s.pin_sync & (s.low_cnt == 13'(RESET_CYC));
    soft_go    = apb_wr & (paddr == tfs_pkg::REG_CTRL) & pwdata[tfs_pkg::CTRL_SOFT_BIT];
    // either source alone or both together give one start
    trig_go    = (pin_trig | soft_go) & (s.state == tfs_pkg::ST_SLEEP)
               & (s.mode == tfs_pkg::MODE_SINGLE);
    frames_eff = (s.frames_cfg == 6'h00) ? 7'h01 : {1'b0, s.frames_cfg};
    // (64 x count + 2) core periods expressed in pclk cycles
    wake_total = 24'((({4'h0, s.wake_cfg, 6'h00}) + 24'(tfs_pkg::WAKE_OFFSET))
               * 24'(tfs_pkg::CORE_DIV));
  end

  // ==========================================================
  // register read mux
  always_comb begin
    rdata  = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == tfs_pkg::REG_CTRL) begin
      rdata[tfs_pkg::CTRL_SOFT_BIT] = s.soft_trig;
    end else if (paddr == tfs_pkg::REG_MODE) begin
      rdata[tfs_pkg::MODE_SEL_LSB +: 2]    = s.mode;
      rdata[tfs_pkg::MODE_FRAMES_LSB +: 6] = s.frames_cfg;
    end else if (paddr == tfs_pkg::REG_WAKE) begin
      rdata[13:0] = s.wake_cfg;
    end else if (paddr == tfs_pkg::REG_FRAME) begin
      rdata[11:0] = s.nsub_cfg;
    end else if (paddr == tfs_pkg::REG_STATUS) begin
      rdata[3:0]                         = s.state;
      rdata[tfs_pkg::STATUS_FR_LSB +: 7] = s.frames_done;
    end else if (paddr == tfs_pkg::REG_RESULT) begin
      rdata[15:0]                          = s.amp;
      rdata[tfs_pkg::RESULT_PH_LSB +: 16]  = s.phase;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.frame_start_strobe = 1'b0;
    next_s.sample_ready       = 1'b0;

    // pin synchroniser and low-width measurement
    next_s.pin_meta = reset_trigger_pin_n;
    next_s.pin_sync = s.pin_meta;
    next_s.pin_prev = s.pin_sync;
    if (!s.pin_sync) begin
      if (s.low_cnt != {tfs_pkg::LOW_CNT_W{1'b1}}) begin
        next_s.low_cnt = s.low_cnt + 13'h0001;
      end
    end else begin
      next_s.low_cnt = '0;
    end

    // apb: one wait state, answer registered
    next_s.pready  = apb_acc & ~s.pready;
    next_s.pslverr = apb_acc & ~s.pready & rd_err;
    next_s.prdata  = (apb_acc & ~s.pready & ~pwrite) ? rdata : 32'h0000_0000;
    if (apb_wr) begin
      if (paddr == tfs_pkg::REG_MODE) begin
        next_s.mode       = pwdata[tfs_pkg::MODE_SEL_LSB +: 2];
        next_s.frames_cfg = pwdata[tfs_pkg::MODE_FRAMES_LSB +: 6];
      end else if (paddr == tfs_pkg::REG_WAKE) begin
        next_s.wake_cfg = pwdata[13:0];
      end else if (paddr == tfs_pkg::REG_FRAME) begin
        next_s.nsub_cfg = pwdata[11:0];
      end
    end

    if (depth_result_valid) begin
      next_s.amp   = depth_amplitude;
      next_s.phase = depth_phase;
    end

    case (s.state)
      tfs_pkg::ST_IDLE: begin
        if (s.mode == tfs_pkg::MODE_CONT) begin
          next_s.state              = tfs_pkg::ST_FRAME;
          next_s.one_shot           = 1'b0;
          next_s.sub_cyc            = '0;
          next_s.sub_idx            = '0;
          next_s.frame_start_strobe = 1'b1;
        end else if (s.mode == tfs_pkg::MODE_SINGLE) begin
          next_s.state = tfs_pkg::ST_SLEEP;
        end
        // other mode codes hold the sequencer idle
      end
      tfs_pkg::ST_SLEEP: begin
        if (s.mode != tfs_pkg::MODE_SINGLE) begin
          next_s.state = tfs_pkg::ST_IDLE;
        end else if (trig_go) begin
          next_s.state       = tfs_pkg::ST_WAKE;
          next_s.wake_cnt    = wake_total - 24'h00_0001;
          next_s.frames_left = frames_eff;
          next_s.frames_done = '0;
          next_s.one_shot    = 1'b1;
          next_s.soft_trig   = soft_go;
        end
      end
      tfs_pkg::ST_WAKE: begin
        if (s.wake_cnt == '0) begin
          next_s.state              = tfs_pkg::ST_FRAME;
          next_s.sub_cyc            = '0;
          next_s.sub_idx            = '0;
          next_s.frame_start_strobe = 1'b1;
        end else begin
          next_s.wake_cnt = s.wake_cnt - 24'h00_0001;
        end
      end
      tfs_pkg::ST_FRAME: begin
        if (s.sub_cyc == 16'(SUBFRAME_CYC - 1)) begin
          next_s.sub_cyc = '0;
          if (s.sub_idx == s.nsub_cfg) begin
            // frame complete, results ready
            next_s.sub_idx      = '0;
            next_s.sample_ready = 1'b1;
            next_s.frames_done  = s.frames_done + 7'h01;
            if (s.one_shot) begin
              next_s.frames_left = s.frames_left - 7'h01;
              if (s.frames_left == 7'h01) begin
                next_s.state     = tfs_pkg::ST_SLEEP;
                next_s.soft_trig = 1'b0;
              end else begin
                next_s.frame_start_strobe = 1'b1;
              end
            end else if (s.mode == tfs_pkg::MODE_CONT) begin
              next_s.frame_start_strobe = 1'b1;
            end else begin
              next_s.state = tfs_pkg::ST_IDLE;
            end
          end else begin
            next_s.sub_idx = s.sub_idx + 12'h001;
          end
        end else begin
          next_s.sub_cyc = s.sub_cyc + 16'h0001;
        end
      end
      default: begin
        next_s.state = tfs_pkg::ST_IDLE;
      end
    endcase

    // long low pulse on the pin restarts the sequencer and its settings
    if (pin_reset) begin
      next_s.state              = tfs_pkg::ST_IDLE;
      next_s.soft_trig          = 1'b0;
      next_s.one_shot           = 1'b0;
      next_s.mode               = tfs_pkg::MODE_RESET;
      next_s.frames_cfg         = tfs_pkg::FRAMES_RESET;
      next_s.wake_cfg           = tfs_pkg::WAKE_RESET;
      next_s.nsub_cfg           = tfs_pkg::NSUB_RESET;
      next_s.frame_start_strobe = 1'b0;
      next_s.sample_ready       = 1'b0;
    end

    // front-end timing derived from the next sub-frame position
    next_s.sensor_integrate = (next_s.state == tfs_pkg::ST_FRAME)
                            & (next_s.sub_cyc < 16'(INTEG_CYC));
    next_s.illum_enable     = next_s.sensor_integrate;
    next_s.depth_compute    = (next_s.state == tfs_pkg::ST_FRAME)
                            & ~next_s.sensor_integrate;
    next_s.deep_sleep       = (next_s.state == tfs_pkg::ST_SLEEP);
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RESET_S;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata             = s.prdata;
  assign pready             = s.pready;
  assign pslverr            = s.pslverr;
  assign frame_start_strobe = s.frame_start_strobe;
  assign sensor_integrate   = s.sensor_integrate;
  assign illum_enable       = s.illum_enable;
  assign depth_compute      = s.depth_compute;
  assign sample_ready       = s.sample_ready;
  assign deep_sleep         = s.deep_sleep;

  // ==========================================================
  // checks
  logic [tfs_pkg::WAKE_CNT_W-1:0] chk_elapsed;
  logic [tfs_pkg::WAKE_CNT_W-1:0] chk_total;
  logic [6:0]                     chk_frames;
  logic [7:0]                     chk_low;
  logic                           chk_in_window;

  // independent low-width count of the synchronised pin
  assign chk_in_window = (chk_low > 8'(tfs_pkg::TRIG_MIN_CYC))
                       && (chk_low < 8'(tfs_pkg::TRIG_MAX_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_elapsed <= '0;
      chk_total   <= '0;
      chk_frames  <= '0;
      chk_low     <= '0;
    end else if (ce) begin
      if (!s.pin_sync) begin
        chk_low <= (chk_low == 8'hFF) ? chk_low : chk_low + 8'h01;
      end else begin
        chk_low <= '0;
      end
      if (trig_go && !pin_reset) begin
        chk_elapsed <= '0;
        chk_total   <= wake_total;
        chk_frames  <= frames_eff;
      end else if (s.state == tfs_pkg::ST_WAKE) begin
        chk_elapsed <= chk_elapsed + 24'h00_0001;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wake_interval;
    ce && s.state == tfs_pkg::ST_WAKE && s.wake_cnt == '0 && !pin_reset
      |=> frame_start_strobe && chk_elapsed == chk_total;
  endproperty
  a_wake_interval: assert property (p_wake_interval)
    else $error("trigger to frame strobe interval wrong");

  property p_discard;
    ce && s.state == tfs_pkg::ST_FRAME && (pin_trig || soft_go) && !pin_reset
      |=> s.state != tfs_pkg::ST_WAKE && !(soft_go && s.soft_trig && !$past(s.soft_trig));
  endproperty
  a_discard: assert property (p_discard)
    else $error("trigger accepted during capture");

  property p_trigger_wakes;
    ce && trig_go && !pin_reset |=> s.state == tfs_pkg::ST_WAKE && !deep_sleep;
  endproperty
  a_trigger_wakes: assert property (p_trigger_wakes)
    else $error("trigger did not wake the sequencer");

  property p_both_sources;
    ce && s.state == tfs_pkg::ST_SLEEP && s.mode == tfs_pkg::MODE_SINGLE
      && pin_trig && soft_go && !pin_reset
      |=> s.state == tfs_pkg::ST_WAKE && s.wake_cnt == $past(wake_total) - 24'h00_0001;
  endproperty
  a_both_sources: assert property (p_both_sources)
    else $error("simultaneous triggers not handled as one");

  property p_sleep_holds;
    ce && s.state == tfs_pkg::ST_SLEEP && s.mode == tfs_pkg::MODE_SINGLE
      && !trig_go && !pin_reset && !apb_wr
      |=> s.state == tfs_pkg::ST_SLEEP && deep_sleep;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("left deep sleep without a trigger");

  property p_soft_clear;
    ce && s.state == tfs_pkg::ST_FRAME && next_s.state == tfs_pkg::ST_SLEEP
      |=> !s.soft_trig && sample_ready && s.frames_done == chk_frames;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("soft trigger or frame count wrong at capture end");

  property p_continuous;
    ce && sample_ready && !s.one_shot && s.mode == tfs_pkg::MODE_CONT
      |-> frame_start_strobe && sensor_integrate && illum_enable;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("continuous mode did not restart a frame");

  property p_pin_reset;
    ce && pin_reset |=> s.state == tfs_pkg::ST_IDLE && s.mode == tfs_pkg::MODE_RESET
      && !s.soft_trig;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("long pin pulse did not reset the sequencer");

  property p_trig_window;
    ce && s.pin_sync && !s.pin_prev && s.state == tfs_pkg::ST_SLEEP
      && s.mode == tfs_pkg::MODE_SINGLE && !soft_go && !pin_reset
      |=> (s.state == tfs_pkg::ST_WAKE) == $past(chk_in_window);
  endproperty
  a_trig_window: assert property (p_trig_window)
    else $error("pin trigger outside pulse window");

  property p_result_capture;
    ce && depth_result_valid |=> s.amp == $past(depth_amplitude)
      && s.phase == $past(depth_phase);
  endproperty
  a_result_capture: assert property (p_result_capture)
    else $error("depth result not stored");

  property p_invalid_mode;
    ce && s.state == tfs_pkg::ST_IDLE && s.mode != tfs_pkg::MODE_CONT
      && s.mode != tfs_pkg::MODE_SINGLE && !pin_reset
      |=> s.state == tfs_pkg::ST_IDLE && !frame_start_strobe;
  endproperty
  a_invalid_mode: assert property (p_invalid_mode)
    else $error("invalid mode started a frame");

  property p_frame_outputs;
    frame_start_strobe |-> sensor_integrate && illum_enable && !depth_compute
      && s.sub_cyc == '0;
  endproperty
  a_frame_outputs: assert property (p_frame_outputs)
    else $error("frame start without front-end timing");

endmodule

`default_nettype wire

//--- verification/tfs_host_model.sv
// host-side model driving the combined reset/trigger pin
`timescale 1ns/1ps
`default_nettype none

module tfs_host_model (
  // clock and pin
  input  wire logic pclk,
  output logic      pin_n
);
  // pin idles high through its pull-up
  initial pin_n = 1'h1;

  // =====================================================
  // low pulse of n clock cycles
  task automatic pulse(input int n);
    @(posedge pclk);
    pin_n <= 1'h0;
    repeat (n) @(posedge pclk);
    pin_n <= 1'h1;
  endtask
endmodule

`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench of the frame trigger sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int SUB_C = 40;
  localparam int INT_C = 30;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        ce = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_n;
  logic        res_vld = 1'h0;
  logic [15:0] res_amp = 16'h0;
  logic [15:0] res_ph = 16'h0;
  logic        frame_start_strobe;
  logic        sensor_integrate;
  logic        illum_enable;
  logic        depth_compute;
  logic        sample_ready;
  logic        deep_sleep;
  logic [31:0] rdata;
  logic        rerr;
  int          err_count = 0;
  int          total_checks = 0;

  always #2.5 pclk = ~pclk;

  tfs_host_model host_u (.pclk(pclk), .pin_n(pin_n));

  tfs_sequencer #(.RESET_CYC(60), .SUBFRAME_CYC(SUB_C), .INTEG_CYC(INT_C)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_trigger_pin_n(pin_n), .depth_result_valid(res_vld),
    .depth_amplitude(res_amp), .depth_phase(res_ph), .frame_start_strobe(frame_start_strobe),
    .sensor_integrate(sensor_integrate), .illum_enable(illum_enable),
    .depth_compute(depth_compute), .sample_ready(sample_ready), .deep_sleep(deep_sleep)
  );

  // =====================================================
  // checking and closing
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic guard(input int i);
    if (i > 3000) begin
      err_count++;
      $display("Error wait limit reached");
      final_report();
    end
  endtask

  // =====================================================
  // apb master and waits
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
      guard(i);
    end while (pready !== 1'h1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wait_ds(input logic v);
    int i;
    i = 0;
    while (deep_sleep !== v) begin
      @(posedge pclk);
      i++;
      guard(i);
    end
  endtask

  // cycles from leaving sleep to the frame start strobe
  task automatic wake_time(input int exp);
    int n;
    wait_ds(1'h0);
    n = 0;
    while (frame_start_strobe !== 1'h1) begin
      @(posedge pclk);
      n++;
      guard(n);
    end
    check("wake_to_strobe", n, exp);
  endtask

  task automatic capture(input int exp);
    int n;
    int i;
    n = 0;
    i = 0;
    while (deep_sleep !== 1'h1) begin
      @(posedge pclk);
      if (sample_ready === 1'h1) n++;
      i++;
      guard(i);
    end
    check("frames_captured", n, exp);
  endtask

  task automatic quiet(input int cyc, input logic ds);
    int n;
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (frame_start_strobe !== 1'h0) n++;
    end
    check("no_strobe", n, 0);
    check("sleep_level", deep_sleep, ds);
  endtask

  // =====================================================
  // scenarios
  task automatic s_regs;
    apb(1'h0, tfs_pkg::REG_MODE, 32'h0);
    check("mode_reset", rdata, 32'h00000004);
    apb(1'h0, tfs_pkg::REG_WAKE, 32'h0);
    check("wake_reset", rdata, 32'h000000FA);
    // scenarios shorten the wake delay to keep runs short
    check("wake_reset_min", ((64 * rdata + 2) * tfs_pkg::CORE_PERIOD_NS >= 400000), 1'h1);
    apb(1'h0, 8'h20, 32'h0);
    check("unmapped_err", rerr, 1'h1);
    $display("test regs done");
  endtask

  task automatic s_cont;
    int i;
    i = 0;
    while (frame_start_strobe !== 1'h1) begin
      @(posedge pclk);
      i++;
      guard(i);
    end
    check("integ_phase", {sensor_integrate, illum_enable, depth_compute}, 3'h6);
    repeat (INT_C) @(posedge pclk);
    check("compute_phase", {sensor_integrate, illum_enable, depth_compute}, 3'h1);
    repeat (SUB_C - INT_C) @(posedge pclk);
    check("next_strobe", frame_start_strobe, 1'h1);
    $display("test continuous done");
  endtask

  task automatic s_result;
    @(posedge pclk);
    res_vld <= 1'h1;
    res_amp <= 16'h1234;
    res_ph  <= 16'hABCD;
    @(posedge pclk);
    res_vld <= 1'h0;
    apb(1'h0, tfs_pkg::REG_RESULT, 32'h0);
    check("result", rdata, 32'hABCD1234);
    $display("test result done");
  endtask

  task automatic s_invalid;
    for (int m = 1; m < 3; m++) begin
      apb(1'h1, tfs_pkg::REG_MODE, 32'h4 | m);
      repeat (2 * SUB_C) @(posedge pclk);
      quiet(100, 1'h0);
    end
    $display("test invalid mode done");
  endtask

  task automatic s_soft;
    apb(1'h1, tfs_pkg::REG_WAKE, 32'h1);
    apb(1'h1, tfs_pkg::REG_MODE, 32'h0B);
    wait_ds(1'h1);
    apb(1'h1, tfs_pkg::REG_CTRL, 32'h1);
    wake_time((64 * 1 + 2) * 5);
    apb(1'h0, tfs_pkg::REG_CTRL, 32'h0);
    check("soft_bit_busy", rdata[0], 1'h1);
    capture(2);
    apb(1'h0, tfs_pkg::REG_CTRL, 32'h0);
    check("soft_bit_clear", rdata[0], 1'h0);
    $display("test soft trigger done");
  endtask

  task automatic s_pin;
    host_u.pulse(40);
    wake_time((64 * 1 + 2) * 5);
    fork
      capture(2);
      begin
        apb(1'h1, tfs_pkg::REG_CTRL, 32'h1);
        host_u.pulse(30);
      end
    join
    quiet(400, 1'h1);
    host_u.pulse(10);
    quiet(400, 1'h1);
    $display("test pin trigger done");
  endtask

  // pin trigger and soft write taken at the same edge
  task automatic s_both;
    fork
      host_u.pulse(40);
      begin
        repeat (40) @(posedge pclk);
        apb(1'h1, tfs_pkg::REG_CTRL, 32'h1);
      end
    join
    wake_time((64 * 1 + 2) * 5);
    apb(1'h0, tfs_pkg::REG_CTRL, 32'h0);
    check("both_soft_bit", rdata[0], 1'h1);
    capture(2);
    $display("test both triggers done");
  endtask

  task automatic s_freeze;
    int i;
    i = 0;
    while (frame_start_strobe !== 1'h1) begin
      @(posedge pclk);
      i++;
      guard(i);
    end
    ce <= 1'h0;
    repeat (20) @(posedge pclk);
    check("frozen_integ", sensor_integrate, 1'h1);
    ce <= 1'h1;
    repeat (SUB_C - 20) @(posedge pclk);
    check("frozen_no_strobe", frame_start_strobe, 1'h0);
    repeat (20) @(posedge pclk);
    check("frozen_late_strobe", frame_start_strobe, 1'h1);
    $display("test clock enable done");
  endtask

  task automatic s_pin_reset;
    host_u.pulse(80);
    wait_ds(1'h0);
    apb(1'h0, tfs_pkg::REG_MODE, 32'h0);
    check("mode_after_pin_reset", rdata, 32'h00000004);
    s_cont();
    $display("test pin reset done");
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    s_regs();
    s_cont();
    s_result();
    s_invalid();
    s_soft();
    s_pin();
    s_both();
    s_pin_reset();
    s_freeze();
    final_report();
  end
endmodule

`default_nettype wire
